/* hw/odp_pkg.sv */
// constants for the eight-channel digital i/o port
// assumes an 8-bit register port with one-cycle read latency
package odp_pkg;
   localparam int ODP_W = 8;
   localparam logic [3:0] ODP_CHAN_LAST = 4'h7;
   // setting selector codes
   localparam logic [3:0] ODP_SEL_DIR = 4'h0;
   localparam logic [3:0] ODP_SEL_PSEL = 4'h1;
   localparam logic [3:0] ODP_SEL_PEN = 4'h2;
   localparam logic [3:0] ODP_SEL_INV = 4'h3;
   localparam logic [3:0] ODP_SEL_HOLD = 4'h4;
   localparam logic [3:0] ODP_SEL_DRIVE = 4'h5;
   localparam logic [3:0] ODP_SEL_MASK = 4'h6;
   // further register indexes within a page
   localparam logic [3:0] ODP_IDX_INPUT = 4'h7;
   localparam logic [3:0] ODP_IDX_STATUS = 4'h8;
   localparam logic [3:0] ODP_IDX_CHSEL = 4'h9;
   localparam logic [3:0] ODP_IDX_ERR = 4'ha;
   localparam logic [3:0] ODP_IDX_OUTVAL = 4'hb;
   // pages: whole-port access and single-channel access
   localparam logic [3:0] ODP_PAGE_PORT = 4'h0;
   localparam logic [3:0] ODP_PAGE_BIT = 4'h1;
   // reset values
   localparam logic [7:0] ODP_RST_DIR = 8'hff;
   localparam logic [7:0] ODP_RST_CFG = 8'h00;
   localparam logic [7:0] ODP_RST_MASK = 8'h00;
   localparam logic ODP_RST_DRIVE = 1'b0;
   localparam logic [3:0] ODP_RST_CHSEL = 4'h0;
endpackage

/* hw/odp_port.sv */
// eight-channel digital i/o port with input hold and shared interrupt
// assumes a register master on CLK and asynchronous pins
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
// Operation
// - direction bit per channel, 1 is input
// - pull select bit, 1 is pull-up
// - pull enable bit per channel
// - open-drain outputs force pull resistor off
// - polarity bit inverts presented input
// - hold mode bit selects latched input
// - live read; change sets pending unless masked
// - live pending clears on read or return
// - held channel captures value, read clears
// - held pending survives return to original
// - input read clears every channel at once
// - leaving hold mode shows live level
// - entering hold mode shows held level
// - one drive-style bit, channel ignored
// - mask bit per channel, 1 blocks
// - one interrupt line while unmasked pending
// - readable per-channel interrupt status
// - port value bit n is channel n
// - selector codes zero through six
// - single-channel number only zero to seven
module odp_port
   import odp_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // pins
   input wire logic [ODP_W-1:0] PIN_I,
   output logic [ODP_W-1:0] PIN_O,
   output logic [ODP_W-1:0] PIN_OE,
   output logic [ODP_W-1:0] PULL_UP_EN,
   output logic [ODP_W-1:0] PULL_DN_EN,
   // shared interrupt
   output logic IRQ
);
   logic [7:0] dir;
   logic [7:0] psel;
   logic [7:0] pen;
   logic [7:0] inv;
   logic [7:0] hold_mode;
   logic [7:0] mask;
   logic [7:0] out_val;
   logic od;
   logic [3:0] chsel;
   logic err;
   logic [7:0] sync_lvl;
   logic [7:0] live;
   logic [7:0] ref_lvl;
   logic [7:0] hold;
   logic [7:0] pend;
   logic [7:0] in_val;
   logic [3:0] page;
   logic [3:0] idx;
   logic chan_ok;
   logic [2:0] ch;
   logic port_wr;
   logic bit_wr;
   logic bad_bit;
   logic rd_in;
   logic [7:0] next_rdata;

   odp_sync #(
      .WIDTH(ODP_W)
   ) u_sync (
      .CLK(CLK),
      .RST(RST),
      .din(PIN_I),
      .dout(sync_lvl)
   );

   assign live = sync_lvl ^ inv;
   // hold-mode channels present the held value, others the live pin
   assign in_val = (hold_mode & hold) | (~hold_mode & live);

   assign page = ADDR[7:4];
   assign idx = ADDR[3:0];
   assign chan_ok = (chsel <= ODP_CHAN_LAST);
   assign ch = chsel[2:0];
   assign port_wr = WR && (page == ODP_PAGE_PORT);
   assign bit_wr = WR && (page == ODP_PAGE_BIT) && chan_ok;
   // single-channel access with a bad channel number is refused, except at the drive-style selector
   assign bad_bit = (WR || RD) && (page == ODP_PAGE_BIT) && !chan_ok
                    && (idx != ODP_SEL_DRIVE);
   // whole-port or single-channel input read clears all channels
   assign rd_in = RD && (idx == ODP_IDX_INPUT)
                  && ((page == ODP_PAGE_PORT)
                      || ((page == ODP_PAGE_BIT) && chan_ok));

   function automatic logic [7:0] cfg_next(input logic [7:0] cur,
                                           input logic pw,
                                           input logic bw,
                                           input logic [7:0] d,
                                           input logic [2:0] c);
      logic [7:0] r;
      r = cur;
      if (pw) begin
         r = d;
      end else if (bw) begin
         r[c] = d[0];
      end
      return r;
   endfunction

   // per-channel settings, port value bit n is channel n
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dir <= ODP_RST_DIR;
         psel <= ODP_RST_CFG;
         pen <= ODP_RST_CFG;
         inv <= ODP_RST_CFG;
         hold_mode <= ODP_RST_CFG;
         mask <= ODP_RST_MASK;
         out_val <= ODP_RST_CFG;
      end else begin
         dir <= cfg_next(dir, port_wr && idx == ODP_SEL_DIR,
                         bit_wr && idx == ODP_SEL_DIR, WDATA, ch);
         psel <= cfg_next(psel, port_wr && idx == ODP_SEL_PSEL,
                          bit_wr && idx == ODP_SEL_PSEL, WDATA, ch);
         pen <= cfg_next(pen, port_wr && idx == ODP_SEL_PEN,
                         bit_wr && idx == ODP_SEL_PEN, WDATA, ch);
         inv <= cfg_next(inv, port_wr && idx == ODP_SEL_INV,
                         bit_wr && idx == ODP_SEL_INV, WDATA, ch);
         hold_mode <= cfg_next(hold_mode, port_wr && idx == ODP_SEL_HOLD,
                               bit_wr && idx == ODP_SEL_HOLD, WDATA, ch);
         mask <= cfg_next(mask, port_wr && idx == ODP_SEL_MASK,
                          bit_wr && idx == ODP_SEL_MASK, WDATA, ch);
         out_val <= cfg_next(out_val, port_wr && idx == ODP_IDX_OUTVAL,
                             bit_wr && idx == ODP_IDX_OUTVAL, WDATA, ch);
      end
   end

   // drive style is global; a single-channel write ignores the channel
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         od <= ODP_RST_DRIVE;
      end else if (WR && idx == ODP_SEL_DRIVE
                   && (page == ODP_PAGE_PORT || page == ODP_PAGE_BIT)) begin
         od <= WDATA[0];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         chsel <= ODP_RST_CHSEL;
      end else if (port_wr && idx == ODP_IDX_CHSEL) begin
         chsel <= WDATA[3:0];
      end
   end

   // sticky refusal flag; a new refusal wins over the read that clears
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         err <= 1'b0;
      end else if (bad_bit) begin
         err <= 1'b1;
      end else if (RD && page == ODP_PAGE_PORT && idx == ODP_IDX_ERR) begin
         err <= 1'b0;
      end
   end

   // change detection against the level seen at the last input read
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ref_lvl <= '0;
         hold <= '0;
         pend <= '0;
      end else begin
         for (int i = 0; i < ODP_W; i++) begin
            if (hold_mode[i]) begin
               if (!pend[i] && live[i] != ref_lvl[i] && !mask[i]) begin
                  // capture wins over a read in the same cycle
                  pend[i] <= 1'b1;
                  hold[i] <= live[i];
               end else if (rd_in) begin
                  pend[i] <= 1'b0;
                  ref_lvl[i] <= hold[i];
               end else if (!pend[i]) begin
                  hold[i] <= live[i];
               end
               // pending and captured value stay until read
            end else begin
               hold[i] <= live[i];
               if (rd_in) begin
                  pend[i] <= 1'b0;
                  ref_lvl[i] <= live[i];
               end else begin
                  // set on change, self-clears on return
                  pend[i] <= (live[i] != ref_lvl[i]) && !mask[i];
               end
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(pend & ~mask);
      end
   end

   // pin drive and pull resistors
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PIN_O <= '0;
         PIN_OE <= '0;
         PULL_UP_EN <= '0;
         PULL_DN_EN <= '0;
      end else begin
         PIN_O <= od ? 8'h00 : out_val;
         PIN_OE <= ~dir & (od ? ~out_val : 8'hff);
         PULL_UP_EN <= pen & psel & ~(~dir & {8{od}});
         PULL_DN_EN <= pen & ~psel & ~(~dir & {8{od}});
      end
   end

   // read multiplexer
   always_comb begin
      next_rdata = 8'h00;
      if (page == ODP_PAGE_PORT) begin
         case (idx)
            ODP_SEL_DIR: next_rdata = dir;
            ODP_SEL_PSEL: next_rdata = psel;
            ODP_SEL_PEN: next_rdata = pen;
            ODP_SEL_INV: next_rdata = inv;
            ODP_SEL_HOLD: next_rdata = hold_mode;
            ODP_SEL_DRIVE: next_rdata = {7'h00, od};
            ODP_SEL_MASK: next_rdata = mask;
            ODP_IDX_INPUT: next_rdata = in_val;
            ODP_IDX_STATUS: next_rdata = pend;
            ODP_IDX_CHSEL: next_rdata = {4'h0, chsel};
            ODP_IDX_ERR: next_rdata = {7'h00, err};
            ODP_IDX_OUTVAL: next_rdata = out_val;
            default: next_rdata = 8'h00;
         endcase
      end else if (page == ODP_PAGE_BIT && idx == ODP_SEL_DRIVE) begin
         next_rdata = {7'h00, od};
      end else if (page == ODP_PAGE_BIT && chan_ok) begin
         case (idx)
            ODP_SEL_DIR: next_rdata = {7'h00, dir[ch]};
            ODP_SEL_PSEL: next_rdata = {7'h00, psel[ch]};
            ODP_SEL_PEN: next_rdata = {7'h00, pen[ch]};
            ODP_SEL_INV: next_rdata = {7'h00, inv[ch]};
            ODP_SEL_HOLD: next_rdata = {7'h00, hold_mode[ch]};
            ODP_SEL_MASK: next_rdata = {7'h00, mask[ch]};
            ODP_IDX_INPUT: next_rdata = {7'h00, in_val[ch]};
            ODP_IDX_STATUS: next_rdata = {7'h00, pend[ch]};
            ODP_IDX_OUTVAL: next_rdata = {7'h00, out_val[ch]};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= RD ? next_rdata : 8'h00;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   sequence s_dir_read;
      RD && ADDR == {ODP_PAGE_PORT, ODP_SEL_DIR};
   endsequence

   sequence s_mask_write;
      WR && ADDR == {ODP_PAGE_PORT, ODP_SEL_MASK};
   endsequence

   property p_dir_readback;
      s_dir_read |=> RDATA == $past(dir);
   endproperty
   a_dir_readback: assert property (p_dir_readback)
      else $error("direction read back wrong");

   property p_mask_write_read;
      s_mask_write ##1 (RD && ADDR == {ODP_PAGE_PORT, ODP_SEL_MASK})
         |=> RDATA == $past(WDATA, 2);
   endproperty
   a_mask_write_read: assert property (p_mask_write_read)
      else $error("mask not stored");

   property p_od_pull_off;
      1'b1 |=> ((PULL_UP_EN | PULL_DN_EN) & ~$past(dir)
                & {8{$past(od)}}) == 8'h00;
   endproperty
   a_od_pull_off: assert property (p_od_pull_off)
      else $error("pull left on for open-drain output");

   property p_input_read;
      (RD && ADDR == {ODP_PAGE_PORT, ODP_IDX_INPUT})
         |=> RDATA == $past(in_val);
   endproperty
   a_input_read: assert property (p_input_read)
      else $error("input register read wrong");

   property p_live_pend;
      !rd_in |=> ((pend ^ (($past(live) ^ $past(ref_lvl)) & ~$past(mask)))
                  & ~$past(hold_mode)) == 8'h00;
   endproperty
   a_live_pend: assert property (p_live_pend)
      else $error("live pending not following the pin");

   property p_read_clears;
      rd_in |=> (pend & ~$past(hold_mode)) == 8'h00;
   endproperty
   a_read_clears: assert property (p_read_clears)
      else $error("input read left live pending set");

   property p_held_stays;
      !rd_in |=> ($past(pend) & $past(hold_mode)
                  & hold_mode & ~pend) == 8'h00;
   endproperty
   a_held_stays: assert property (p_held_stays)
      else $error("held pending lost without a read");

   property p_drive_any_chan;
      (WR && ADDR == {ODP_PAGE_BIT, ODP_SEL_DRIVE})
         |=> od == $past(WDATA[0]);
   endproperty
   a_drive_any_chan: assert property (p_drive_any_chan)
      else $error("drive style write refused");

   property p_bad_chan;
      (WR && page == ODP_PAGE_BIT && !chan_ok && idx != ODP_SEL_DRIVE)
         |=> dir == $past(dir) && err;
   endproperty
   a_bad_chan: assert property (p_bad_chan)
      else $error("bad channel write accepted");

   property p_irq;
      (|(pend & ~mask)) |=> IRQ;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt line not raised");

   property p_irq_low;
      !(|(pend & ~mask)) |=> !IRQ;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("interrupt line high with nothing pending");
endmodule

/* hw/odp_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to CLK
`timescale 1ns/1ps
module odp_sync #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // pins in, filtered level out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a level counts only once stages two and three agree
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dout <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2[i] == s3[i]) begin
               dout[i] <= s3[i];
            end
         end
      end
   end
endmodule

/* sim/odp_pins.sv */
// pad model standing outside the eight-channel port
// assumes the bench supplies external levels and which of them are driven
`timescale 1ns/1ps
module odp_pins (
   // clock
   input wire logic CLK,
   // port side of the pads
   input wire logic [7:0] pin_o,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pu,
   input wire logic [7:0] pd,
   // outside world
   input wire logic [7:0] ext,
   input wire logic [7:0] ext_en,
   output logic [7:0] lvl
);
   logic [7:0] last = 8'h00;
   always_ff @(posedge CLK) begin
      last <= lvl;
   end
   // a pad nobody holds wanders: show the inverse of its last level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pin_oe[i]) lvl[i] = pin_o[i];
         else if (ext_en[i]) lvl[i] = ext[i];
         else if (pu[i]) lvl[i] = 1'b1;
         else if (pd[i]) lvl[i] = 1'b0;
         else lvl[i] = ~last[i];
      end
   end
endmodule

/* sim/tb.sv */
// self-checking bench for the eight-channel port
// assumes the pad model in odp_pins and a register port master here
`timescale 1ns/1ps
module tb;
   import odp_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] ext = 8'h00;
   logic [7:0] ext_en = 8'hff;
   logic [7:0] rdata, pin_i, pin_o, pin_oe, pu, pd;
   logic irq;
   int bad_count = 0;
   int n_compared = 0;
   logic [31:0] seed = 32'hc4d0;
   logic [7:0] v, q, inv, dir, pen, psel;
   always #50 clk = ~clk;
   odp_port u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .PIN_I(pin_i), .PIN_O(pin_o),
      .PIN_OE(pin_oe), .PULL_UP_EN(pu), .PULL_DN_EN(pd), .IRQ(irq));
   odp_pins u_pins (.CLK(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pu(pu),
      .pd(pd), .ext(ext), .ext_en(ext_en), .lvl(pin_i));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   // expected pull enables: open-drain outputs lose their pull
   function automatic logic [7:0] exp_pull(input logic up, input logic od);
      logic [7:0] kill;
      kill = ~dir & {8{od}};
      return pen & (up ? psel : ~psel) & ~kill;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // write then read back with no gap between the two strobes
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bus_rd(a, d);
      chk(d, exp);
   endtask
   // flip pins, then wait out the synchroniser and the event path
   task automatic pin(input logic [7:0] m);
      @(posedge clk);
      ext <= ext ^ m;
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // the tests need well under a thousand cycles; allow thirty thousand
   initial begin
      #3_000_000;
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rdchk(8'h00, ODP_RST_DIR);
      for (int i = 1; i < 5; i++) begin
         rdchk(8'(i), ODP_RST_CFG);
      end
      rdchk(8'h05, {7'h00, ODP_RST_DRIVE});
      rdchk(8'h06, ODP_RST_MASK);
      rdchk(8'h0c, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 8; i++) begin
         q = (i == 5) ? 8'h06 : 8'(i % 5);
         inv = rnd();
         wr_rd(q, inv);
      end
      bus_wr(8'h05, 8'hff);
      rdchk(8'h05, 8'h01);
      $display("test readback done");
      bus_wr(8'h05, 8'h01);
      dir = 8'hf0;
      pen = 8'hff;
      psel = rnd();
      bus_wr(8'h00, dir);
      bus_wr(8'h02, pen);
      bus_wr(8'h01, psel);
      q = rnd();
      bus_wr(8'h0b, q);
      for (int od = 1; od >= 0; od--) begin
         bus_wr(8'h05, 8'(od));
         repeat (3) @(posedge clk);
         #1;
         chk(pu, exp_pull(1'b1, od[0]));
         chk(pd, exp_pull(1'b0, od[0]));
         chk(pin_o, od[0] ? 8'h00 : q);
         chk(pin_oe, ~dir & (od[0] ? ~q : 8'hff));
      end
      chk(pin_oe, ~dir);
      bus_wr(8'h00, 8'hff);
      bus_wr(8'h02, 8'h00);
      bus_wr(8'h06, 8'h00);
      bus_wr(8'h04, 8'h00);
      $display("test pulls done");
      for (int k = 0; k < 4; k++) begin
         inv = rnd();
         bus_wr(8'h03, inv);
         pin(rnd());
         rdchk(8'h07, ext ^ inv);
         rdchk(8'h08, 8'h00);
         chk({7'h00, irq}, 8'h00);
      end
      pin(8'h10);
      rdchk(8'h08, 8'h10);
      chk({7'h00, irq}, 8'h01);
      pin(8'h10);
      rdchk(8'h08, 8'h00);
      chk({7'h00, irq}, 8'h00);
      bus_wr(8'h06, 8'h10);
      pin(8'h14);
      rdchk(8'h08, 8'h04);
      rdchk(8'h07, ext ^ inv);
      rdchk(8'h08, 8'h00);
      bus_wr(8'h06, 8'h00);
      $display("test live input done");
      v = ext ^ inv;
      bus_wr(8'h04, 8'hff);
      pin(8'h01);
      pin(8'h01);
      rdchk(8'h08, 8'h01);
      chk({7'h00, irq}, 8'h01);
      rdchk(8'h07, v ^ 8'h01);
      repeat (5) @(posedge clk);
      rdchk(8'h07, v);
      bus_wr(8'h09, 8'h03);
      pin(8'h28);
      rdchk(8'h17, {7'h00, ~v[3]});
      rdchk(8'h08, 8'h00);
      v = ext ^ inv;
      pin(8'h40);
      pin(8'h40);
      bus_wr(8'h04, 8'h00);
      rdchk(8'h07, v);
      // release the pads: the pull resistors alone set the levels
      bus_wr(8'h02, 8'hff);
      @(posedge clk);
      ext_en <= 8'h00;
      repeat (10) @(posedge clk);
      rdchk(8'h07, psel ^ inv);
      @(posedge clk);
      ext_en <= 8'hff;
      $display("test held input done");
      bus_wr(8'h09, 8'h09);
      rdchk(8'h10, 8'h00);
      bus_wr(8'h10, 8'h00);
      bus_wr(8'h15, 8'h01);
      rdchk(8'h15, 8'h01);
      rdchk(8'h0a, 8'h01);
      bus_wr(8'h09, 8'h00);
      rdchk(8'h00, 8'hff);
      rdchk(8'h05, 8'h01);
      $display("test channel select done");
      complete_run();
   end
endmodule
